// [bench/pps_link_partner.sv]
/*
  Link partner model: an unpowered inline device that returns search
  pulses, or a live partner that shows energy and then link.
  Assumes the bench drives its controls on SYS_CLK.
*/
`timescale 1ns/10ps

module pps_link_partner (
  // Clock
  input  wire logic SYS_CLK,
  // From the transceiver
  input  wire logic SPECIAL_FLP_EN,
  // Bench controls
  input  wire logic pd_present,
  input  wire logic poe_on,
  input  wire logic cable_in,
  // Media pins and link
  output logic      FLP_LOOPBACK = 1'h0,
  output logic      ENERGY_DET = 1'h0,
  output logic      LINK_UP = 1'h0
);
  logic [3:0] up_cnt_r = 4'h0;
  logic       live;

  assign live = cable_in || (pd_present && poe_on);

  always @(posedge SYS_CLK) begin
    // Unpowered device shorts the pairs
    FLP_LOOPBACK <= pd_present && !poe_on && SPECIAL_FLP_EN;
    ENERGY_DET   <= live;
    up_cnt_r     <= live ? up_cnt_r + {3'h0, up_cnt_r != 4'h8} : 4'h0;
    LINK_UP      <= live && up_cnt_r == 4'h8;
  end
endmodule // pps_link_partner

// [bench/pps_sequencer_assertions.sv]
/*
  Port checker of the power sequencer, bound into pps_sequencer.
  Assumes one clock domain and the package and constants of the design.
*/
`timescale 1ns/10ps
`include "pps_consts.svh"

module pps_sequencer_chk
  import pps_pkg::*;
(
  // Clock and reset
  input wire logic                SYS_CLK,
  input wire logic                SYS_RST,
  // Inputs
  input wire logic                ENERGY_DET,
  input wire logic                LINK_UP,
  input wire pps_pkg::pps_speed_t SPEED,
  input wire logic                LPI_REQ,
  input wire logic                MAGIC_VALID,
  // Outputs
  input wire logic                LPI_IDLE_EN,
  input wire logic                REDUCED_AMP_10,
  input wire logic                DIGITAL_PWR_DN,
  input wire logic                SPECIAL_FLP_EN,
  input wire logic                AUTONEG_RUN,
  input wire logic                FLP_BURST,
  input wire logic                LINK_STATUS,
  input wire logic [1:0]          PD_DETECT_STATUS,
  input wire logic                WAKE_IRQ,
  input wire logic                WAKE_LED
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  // ********
  // Properties
  // ********
  a_lpi_speed_gate: assert property (
    LPI_IDLE_EN |-> LPI_REQ && LINK_UP && SPEED inside {`PPS_SPD_100, `PPS_SPD_1000})
    else $error("Idle cycling outside 100 or 1000 link");
  a_lpi_amp_off: assert property (
    LPI_IDLE_EN && SPEED == `PPS_SPD_100 |-> !REDUCED_AMP_10)
    else $error("Idle cycling at 100 with receive disable set");
  a_irq_cause: assert property (
    $rose(WAKE_IRQ) |-> $past(MAGIC_VALID))
    else $error("Wake interrupt without magic packet");
  a_irq_led_pair: assert property (
    WAKE_IRQ == WAKE_LED)
    else $error("Wake LED differs from interrupt");
  a_search_status: assert property (
    SPECIAL_FLP_EN |-> PD_DETECT_STATUS == `PPS_DET_SEARCHING)
    else $error("Search pulses with nonzero status");
  a_det_result: assert property (
    $changed(PD_DETECT_STATUS) && PD_DETECT_STATUS != `PPS_DET_SEARCHING
      |-> $past(SPECIAL_FLP_EN) && !SPECIAL_FLP_EN && AUTONEG_RUN)
    else $error("Detection result outside search");
  a_link_follow: assert property (
    LINK_STATUS == $past(LINK_UP))
    else $error("Link status not one cycle after link");
  a_energy_normal: assert property (
    ENERGY_DET [*4] |-> ##[0:2] !DIGITAL_PWR_DN)
    else $error("Energy did not leave low power");
  a_burst_awake: assert property (
    FLP_BURST |-> !DIGITAL_PWR_DN)
    else $error("Burst while powered down");
  a_burst_gap: assert property (
    FLP_BURST |=> !FLP_BURST [*8])
    else $error("Bursts too close");

  c_det_loop: cover property (PD_DETECT_STATUS == `PPS_DET_NEEDS_PWR);
  c_det_none: cover property (PD_DETECT_STATUS == `PPS_DET_NO_LOOP);
  c_irq: cover property ($rose(WAKE_IRQ));
  c_bursts: cover property (FLP_BURST ##[1:300] FLP_BURST);
endmodule // pps_sequencer_chk

bind pps_sequencer pps_sequencer_chk i_pps_sequencer_chk (
  .SYS_CLK, .SYS_RST, .ENERGY_DET, .LINK_UP, .SPEED, .LPI_REQ, .MAGIC_VALID,
  .LPI_IDLE_EN, .REDUCED_AMP_10, .DIGITAL_PWR_DN, .SPECIAL_FLP_EN, .AUTONEG_RUN,
  .FLP_BURST, .LINK_STATUS, .PD_DETECT_STATUS, .WAKE_IRQ, .WAKE_LED);

// [bench/pps_sequencer_bench.sv]
/*
  Self-checking bench of the power sequencer with a link partner model.
  Assumes design, package, partner model and checker are compiled.
*/
`timescale 1ns/10ps
`include "pps_consts.svh"

module pps_sequencer_bench;
  import pps_pkg::*;

  logic        SYS_CLK = 1'h0, SYS_RST = 1'h1;
  logic        PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA;
  logic [3:0]  PSTRB = 4'hF;
  logic        PREADY, PSLVERR, ENERGY_DET, FLP_LOOPBACK, LINK_UP;
  pps_speed_t  SPEED = `PPS_SPD_10;
  logic        LPI_REQ = 1'h0, MAGIC_VALID = 1'h0, MAGIC_PASS_OK = 1'h0;
  logic [47:0] MAGIC_ADDR = 48'h0;
  logic        LPI_IDLE_EN, REDUCED_AMP_10, DIGITAL_PWR_DN, SPECIAL_FLP_EN, AUTONEG_RUN;
  logic        FLP_BURST, FLP_PAIR_B, LINK_STATUS, WAKE_IRQ, WAKE_LED;
  logic [1:0]  PD_DETECT_STATUS;
  logic        pd_present = 1'h0, poe_on = 1'h0, cable_in = 1'h0;
  int          num_errors = 0, check_count = 0, n;

  pps_sequencer #(.MS_CYCLES(10), .SLEEP_MS1(100), .LINK_MS0(2), .DET_MS(5))
    i_pps_sequencer (.*);
  pps_link_partner i_pps_link_partner (.*);

  always #5 SYS_CLK = ~SYS_CLK;

  // ********
  // Helpers
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic err, output logic [31:0] q);
    PSEL    <= 1'h1;
    PWRITE  <= wr;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'h1;
    @(posedge SYS_CLK);
    while (PREADY !== 1'h1) @(posedge SYS_CLK);
    q = PRDATA;
    chk(PSLVERR, err);
    PSEL    <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge SYS_CLK);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'h1, a, d, 1'h0, q);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    apb(1'h0, a, 32'h0, 1'h0, q);
  endtask

  task automatic magic(input logic [47:0] a, input logic p);
    MAGIC_VALID   <= 1'h1;
    MAGIC_ADDR    <= a;
    MAGIC_PASS_OK <= p;
    @(posedge SYS_CLK);
    MAGIC_VALID <= 1'h0;
    repeat (3) @(posedge SYS_CLK);
  endtask

  task automatic results;
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ********
  // Scenarios
  // ********
  task automatic t_reset;
    logic [31:0] q;
    rd(`PPS_OFS_CTRL, q);
    chk(q, 32'h08);
    rd(`PPS_OFS_TIMERS, q);
    chk(q, 32'h01);
    rd(`PPS_OFS_STATUS, q);
    chk(q, 32'h00);
    apb(1'h0, 12'h01C, 32'h0, 1'h1, q);
    chk(q, 32'h00);
  endtask

  task automatic t_lpi;
    cable_in <= 1'h1;
    LPI_REQ  <= 1'h1;
    wr(`PPS_OFS_CTRL, 32'h48);
    for (n = 0; n < 20 && LINK_UP !== 1'h1; n++) @(posedge SYS_CLK);
    chk(LPI_IDLE_EN, 1'h0);
    SPEED <= `PPS_SPD_1000;
    repeat (2) @(posedge SYS_CLK);
    chk(LPI_IDLE_EN, 1'h1);
    SPEED <= `PPS_SPD_100;
    repeat (2) @(posedge SYS_CLK);
    chk(LPI_IDLE_EN, 1'h1);
    wr(`PPS_OFS_CTRL, 32'h49);
    chk(REDUCED_AMP_10, 1'h1);
    chk(LPI_IDLE_EN, 1'h0);
    cable_in <= 1'h0;
    LPI_REQ  <= 1'h0;
    wr(`PPS_OFS_CTRL, 32'h08);
  endtask

  task automatic t_wake;
    logic [31:0] q;
    wr(`PPS_OFS_WAKE_CFG, 32'h01);
    wr(`PPS_OFS_WADDR_LO, 32'h89ABCDEF);
    wr(`PPS_OFS_WADDR_HI, 32'h4567);
    wr(`PPS_OFS_CTRL, 32'h18);
    magic(48'h456789ABCDEE, 1'h0);
    chk(WAKE_IRQ, 1'h0);
    magic(48'h456789ABCDEF, 1'h0);
    chk(WAKE_IRQ, 1'h1);
    chk(WAKE_LED, 1'h1);
    rd(`PPS_OFS_IRQ_STAT, q);
    chk(q[0], 1'h1);
    wr(`PPS_OFS_IRQ_STAT, 32'h01);
    repeat (2) @(posedge SYS_CLK);
    chk(WAKE_IRQ, 1'h0);
    wr(`PPS_OFS_WAKE_CFG, 32'h03);
    magic(48'h456789ABCDEF, 1'h0);
    chk(WAKE_IRQ, 1'h0);
    magic(48'h456789ABCDEF, 1'h1);
    chk(WAKE_IRQ, 1'h1);
    wr(`PPS_OFS_IRQ_STAT, 32'h01);
    wr(`PPS_OFS_CTRL, 32'h08);
  endtask

  task automatic t_detect;
    wr(`PPS_OFS_CTRL, 32'h0C);
    @(posedge SYS_CLK);
    chk(SPECIAL_FLP_EN, 1'h1);
    chk(PD_DETECT_STATUS, `PPS_DET_SEARCHING);
    pd_present <= 1'h1;
    for (n = 0; n < 20 && PD_DETECT_STATUS !== 2'h1; n++) @(posedge SYS_CLK);
    chk(PD_DETECT_STATUS, `PPS_DET_NEEDS_PWR);
    poe_on <= 1'h1;
    for (n = 0; n < 30 && LINK_STATUS !== 1'h1; n++) @(posedge SYS_CLK);
    chk(LINK_STATUS, 1'h1);
    pd_present <= 1'h0;
    for (n = 0; n < 10 && LINK_STATUS !== 1'h0; n++) @(posedge SYS_CLK);
    poe_on <= 1'h0;
    for (n = 0; n < 10 && SPECIAL_FLP_EN !== 1'h1; n++) @(posedge SYS_CLK);
    chk(PD_DETECT_STATUS, `PPS_DET_SEARCHING);
    for (n = 0; n < 100 && PD_DETECT_STATUS !== 2'h2; n++) @(posedge SYS_CLK);
    chk(PD_DETECT_STATUS, `PPS_DET_NO_LOOP);
    chk(SPECIAL_FLP_EN, 1'h0);
    chk(AUTONEG_RUN, 1'h1);
    wr(`PPS_OFS_CTRL, 32'h08);
    chk(PD_DETECT_STATUS, `PPS_DET_NO_LOOP);
  endtask

  task automatic t_psave;
    logic [31:0] q;
    logic        p0, p1;
    int          b;
    wr(`PPS_OFS_TIMERS, 32'h09);
    wr(`PPS_OFS_CTRL, 32'h0A);
    @(posedge SYS_CLK);
    chk(DIGITAL_PWR_DN, 1'h1);
    for (n = 0; n < 2000 && FLP_BURST !== 1'h1; n++) @(posedge SYS_CLK);
    chk(DIGITAL_PWR_DN, 1'h0);
    p0 = FLP_PAIR_B;
    p1 = p0;
    b  = 1;
    for (n = 0; n < 1000 && DIGITAL_PWR_DN !== 1'h1; n++) begin
      @(posedge SYS_CLK);
      if (FLP_BURST === 1'h1) begin
        b++;
        if (b == 2) p1 = FLP_PAIR_B;
      end
    end
    chk({31'h0, b > 1 && b < 4}, 32'h1);
    chk(p1, !p0);
    chk(DIGITAL_PWR_DN, 1'h1);
    cable_in <= 1'h1;
    for (n = 0; n < 10 && DIGITAL_PWR_DN !== 1'h0; n++) @(posedge SYS_CLK);
    chk(DIGITAL_PWR_DN, 1'h0);
    for (n = 0; n < 20 && LINK_STATUS !== 1'h1; n++) @(posedge SYS_CLK);
    rd(`PPS_OFS_STATUS, q);
    chk(q[6:5], 2'h3);
    cable_in <= 1'h0;
    repeat (8) @(posedge SYS_CLK);
    chk(DIGITAL_PWR_DN, 1'h0);
    for (n = 0; n < 40 && DIGITAL_PWR_DN !== 1'h1; n++) @(posedge SYS_CLK);
    chk(DIGITAL_PWR_DN, 1'h1);
    wr(`PPS_OFS_CTRL, 32'h02);
    cable_in <= 1'h1;
    for (n = 0; n < 30 && LINK_STATUS !== 1'h1; n++) @(posedge SYS_CLK);
    cable_in <= 1'h0;
    repeat (60) @(posedge SYS_CLK);
    chk(DIGITAL_PWR_DN, 1'h0);
    cable_in <= 1'h1;
    wr(`PPS_OFS_CTRL, 32'h0A);
    for (n = 0; n < 30 && LINK_STATUS !== 1'h1; n++) @(posedge SYS_CLK);
    wr(`PPS_OFS_CTRL, 32'h02);
    cable_in <= 1'h0;
    repeat (60) @(posedge SYS_CLK);
    chk(DIGITAL_PWR_DN, 1'h0);
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    #300000;
    num_errors++;
    results;
  end

  initial begin
    repeat (6) @(posedge SYS_CLK);
    SYS_RST <= 1'h0;
    @(posedge SYS_CLK);
    t_reset;
    t_lpi;
    t_wake;
    t_detect;
    t_psave;
    results;
  end
endmodule // pps_sequencer_bench

// [hdl/pps_sequencer.sv]
/*
  Per-port power-management sequencer of a copper transceiver: low
  power idle gating, reduced-amplitude 10 Mbps mode, magic-packet wake,
  inline-powered device detection and the automatic power-save machine.
  Assumes an APB master on SYS_CLK, energy and loopback detectors on
  pins, and link, speed and magic-packet decode from same-clock logic.
*/
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps

module pps_sequencer
  import pps_pkg::*;
#(
  parameter int MS_CYCLES = `PPS_MS_NS / `PPS_CLK_NS,
  parameter int SLEEP_MS0 = 1000,
  parameter int SLEEP_MS1 = 2000,
  parameter int SLEEP_MS2 = 3000,
  parameter int SLEEP_MS3 = 4000,
  parameter int WAKE_MS0  = 16,
  parameter int WAKE_MS1  = 32,
  parameter int WAKE_MS2  = 48,
  parameter int WAKE_MS3  = 64,
  parameter int LINK_MS0  = 1000,
  parameter int LINK_MS1  = 2000,
  parameter int LINK_MS2  = 3000,
  parameter int LINK_MS3  = 4000,
  parameter int DET_MS    = 500
) (
  // Clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              SYS_RST,
  // APB slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [11:0]       PADDR,
  input  wire logic [31:0]       PWDATA,
  input  wire logic [3:0]        PSTRB,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  // Media pins
  input  wire logic              ENERGY_DET,
  input  wire logic              FLP_LOOPBACK,
  // Same-clock link logic
  input  wire logic              LINK_UP,
  input  wire pps_pkg::pps_speed_t SPEED,
  input  wire logic              LPI_REQ,
  // Magic-packet decoder
  input  wire logic              MAGIC_VALID,
  input  wire logic [47:0]       MAGIC_ADDR,
  input  wire logic              MAGIC_PASS_OK,
  // Controls towards the transceiver
  output logic                   LPI_IDLE_EN,
  output logic                   REDUCED_AMP_10,
  output logic                   DIGITAL_PWR_DN,
  output logic                   SPECIAL_FLP_EN,
  output logic                   AUTONEG_RUN,
  output logic                   FLP_BURST,
  output logic                   FLP_PAIR_B,
  output logic                   LINK_STATUS,
  output logic [1:0]             PD_DETECT_STATUS,
  // Wake indication
  output logic                   WAKE_IRQ,
  output logic                   WAKE_LED
);

  // ****************************************************
  // State
  // ****************************************************
  pps_state_t s_r;
  pps_state_t s_nxt;

  logic        wr_en;
  logic        rd_en;
  logic        mapped;
  logic [31:0] rd_val;
  logic [31:0] wmask;
  logic        energy;
  logic        loopback;
  logic        an_en;
  logic        ps_en;
  logic        link_drop;
  logic        magic_hit;
  logic [12:0] sleep_ms;
  logic [12:0] wake_ms;
  logic [12:0] link_ms;
  logic [7:0]  rnd_ofs;

  assign wr_en    = PSEL && PENABLE && PWRITE;
  assign rd_en    = PSEL && !PENABLE && !PWRITE;
  assign energy   = s_r.en_sync[1];
  assign loopback = s_r.lb_sync[1];
  assign an_en    = s_r.ctrl[`PPS_B_AN_EN];
  assign ps_en    = s_r.ctrl[`PPS_B_PS_EN];
  assign link_drop = s_r.link_q && !LINK_UP;

  // Byte lanes into a word mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_strb
      assign wmask[gi*8 +: 8] = {8{PSTRB[gi]}};
    end
  endgenerate

  // ****************************************************
  // Duration tables
  // ****************************************************
  always_comb begin
    unique case (s_r.tmr[1:0])
      2'h0: sleep_ms = 13'(SLEEP_MS0);
      2'h1: sleep_ms = 13'(SLEEP_MS1);
      2'h2: sleep_ms = 13'(SLEEP_MS2);
      2'h3: sleep_ms = 13'(SLEEP_MS3);
    endcase
    unique case (s_r.tmr[3:2])
      2'h0: wake_ms = 13'(WAKE_MS0);
      2'h1: wake_ms = 13'(WAKE_MS1);
      2'h2: wake_ms = 13'(WAKE_MS2);
      2'h3: wake_ms = 13'(WAKE_MS3);
    endcase
    unique case (s_r.tmr[5:4])
      2'h0: link_ms = 13'(LINK_MS0);
      2'h1: link_ms = 13'(LINK_MS1);
      2'h2: link_ms = 13'(LINK_MS2);
      2'h3: link_ms = 13'(LINK_MS3);
    endcase
  end

  // Random sleep offset 0..140, shifted by -80 ms on load
  assign rnd_ofs = 8'(s_r.lfsr[7:0] % 8'(`PPS_RND_SPAN));

  // Address and password match against this port's settings
  assign magic_hit = MAGIC_VALID && s_r.ctrl[`PPS_B_WAKE_MASK]
                     && s_r.wcfg[`PPS_B_WAKE_EN] && (MAGIC_ADDR == s_r.waddr)
                     && (!s_r.wcfg[`PPS_B_PASS_EN] || MAGIC_PASS_OK);

  // ****************************************************
  // Read mux
  // ****************************************************
  always_comb begin
    rd_val = 32'h0000_0000;
    mapped = 1'b1;
    unique case (PADDR)
      `PPS_OFS_CTRL:     rd_val[`PPS_CTRL_W-1:0] = s_r.ctrl;
      `PPS_OFS_TIMERS:   rd_val[`PPS_TMR_W-1:0]  = s_r.tmr;
      `PPS_OFS_STATUS:   rd_val[7:0] = {s_r.pend, s_r.ps, s_r.det,
                                        LINK_UP, s_r.det_stat};
      `PPS_OFS_IRQ_STAT: rd_val[0] = s_r.pend;
      `PPS_OFS_WAKE_CFG: rd_val[`PPS_WCFG_W-1:0] = s_r.wcfg;
      `PPS_OFS_WADDR_LO: rd_val = s_r.waddr[31:0];
      `PPS_OFS_WADDR_HI: rd_val[15:0] = s_r.waddr[47:32];
      default:           mapped = 1'b0;
    endcase
    if (PADDR == `PPS_OFS_STATUS) begin
      rd_val[1:0] = s_r.det_stat;
      rd_val[2]   = LINK_UP;
    end
  end

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    s_nxt = s_r;

    // Pin synchronisers
    s_nxt.en_sync = {s_r.en_sync[0], ENERGY_DET};
    s_nxt.lb_sync = {s_r.lb_sync[0], FLP_LOOPBACK};
    s_nxt.link_q  = LINK_UP;
    s_nxt.lfsr    = {s_r.lfsr[14:0],
                     s_r.lfsr[15] ^ s_r.lfsr[13] ^ s_r.lfsr[12] ^ s_r.lfsr[10]};

    // Millisecond enable
    s_nxt.tick = 1'b0;
    if (s_r.ms_cnt == 17'(MS_CYCLES - 1)) begin
      s_nxt.ms_cnt = 17'h0_0000;
      s_nxt.tick   = 1'b1;
    end else begin
      s_nxt.ms_cnt = s_r.ms_cnt + 17'h0_0001;
    end

    // APB
    s_nxt.pslverr = 1'b0;
    if (PSEL && !PENABLE) begin
      s_nxt.pslverr = !mapped;
      if (rd_en) begin
        s_nxt.prdata = rd_val;
      end
    end
    if (wr_en) begin
      unique case (PADDR)
        `PPS_OFS_CTRL:
          s_nxt.ctrl = `PPS_CTRL_W'((s_r.ctrl & ~wmask[`PPS_CTRL_W-1:0])
                       | (PWDATA[`PPS_CTRL_W-1:0] & wmask[`PPS_CTRL_W-1:0]));
        `PPS_OFS_TIMERS:
          if (PSTRB[0]) begin
            s_nxt.tmr = PWDATA[`PPS_TMR_W-1:0];
          end
        `PPS_OFS_WAKE_CFG:
          if (PSTRB[0]) begin
            s_nxt.wcfg = PWDATA[`PPS_WCFG_W-1:0];
          end
        `PPS_OFS_WADDR_LO:
          s_nxt.waddr[31:0] = (s_r.waddr[31:0] & ~wmask) | (PWDATA & wmask);
        `PPS_OFS_WADDR_HI:
          s_nxt.waddr[47:32] = (s_r.waddr[47:32] & ~wmask[15:0])
                               | (PWDATA[15:0] & wmask[15:0]);
        `PPS_OFS_IRQ_STAT:
          if (PSTRB[0] && PWDATA[0]) begin
            s_nxt.pend = 1'b0;
          end
        default: ;
      endcase
    end

    // Wake pending: set wins over a clear in the same cycle
    if (magic_hit) begin
      s_nxt.pend = 1'b1;
    end
    s_nxt.irq = s_nxt.pend && s_nxt.ctrl[`PPS_B_WAKE_MASK];

    // ****************************************************
    // Inline-powered device detection
    // ****************************************************
    if (!s_r.ctrl[`PPS_B_PD_DET_EN] || !an_en) begin
      s_nxt.det = DET_IDLE;
    end else begin
      unique case (s_r.det)
        DET_IDLE: begin
          s_nxt.det      = DET_SEARCH;
          s_nxt.det_stat = `PPS_DET_SEARCHING;
          s_nxt.det_cnt  = 16'h0000;
        end
        DET_SEARCH: begin
          if (loopback) begin
            s_nxt.det      = DET_NEG;
            s_nxt.det_stat = `PPS_DET_NEEDS_PWR;
          end else if (s_r.det_cnt == 16'(DET_MS)) begin
            s_nxt.det      = DET_NEG;
            s_nxt.det_stat = `PPS_DET_NO_LOOP;
          end else if (s_r.tick) begin
            s_nxt.det_cnt = s_r.det_cnt + 16'h0001;
          end
        end
        DET_NEG: begin
          if (link_drop) begin
            s_nxt.det      = DET_SEARCH;
            s_nxt.det_stat = `PPS_DET_SEARCHING;
            s_nxt.det_cnt  = 16'h0000;
          end
        end
      endcase
    end

    // ****************************************************
    // Automatic power save
    // ****************************************************
    if (!ps_en) begin
      s_nxt.ps = PS_OFF;
    end else begin
      unique case (s_r.ps)
        PS_OFF: begin
          s_nxt.ps     = LINK_UP ? PS_NORMAL : PS_LOW;
          s_nxt.ps_cnt = 13'(sleep_ms + 13'(rnd_ofs) - 13'(`PPS_RND_NEG_MS));
        end
        PS_LOW: begin
          if (energy) begin
            s_nxt.ps     = PS_NORMAL;
            s_nxt.ps_cnt = link_ms;
          end else if (s_r.ps_cnt == 13'h0000) begin
            s_nxt.ps      = PS_WAKE;
            s_nxt.ps_cnt  = wake_ms;
            s_nxt.burst_t = 5'h00;
            s_nxt.bursts  = 2'h0;
          end else if (s_r.tick) begin
            s_nxt.ps_cnt = s_r.ps_cnt - 13'h0001;
          end
        end
        PS_WAKE: begin
          if (energy) begin
            s_nxt.ps     = PS_NORMAL;
            s_nxt.ps_cnt = link_ms;
          end else if (s_r.ps_cnt == 13'h0000) begin
            s_nxt.ps     = PS_LOW;
            s_nxt.ps_cnt = 13'(sleep_ms + 13'(rnd_ofs) - 13'(`PPS_RND_NEG_MS));
          end else if (s_r.tick) begin
            s_nxt.ps_cnt = s_r.ps_cnt - 13'h0001;
            if (s_r.burst_t == 5'h00) begin
              s_nxt.burst_t = 5'(`PPS_BURST_MS - 1);
            end else begin
              s_nxt.burst_t = s_r.burst_t - 5'h01;
            end
          end
        end
        PS_NORMAL: begin
          if (LINK_UP) begin
            s_nxt.ps_cnt = link_ms;
          end else if (!an_en) begin
            s_nxt.ps_cnt = link_ms;
          end else if (s_r.ps_cnt == 13'h0000) begin
            s_nxt.ps     = PS_LOW;
            s_nxt.ps_cnt = 13'(sleep_ms + 13'(rnd_ofs) - 13'(`PPS_RND_NEG_MS));
          end else if (s_r.tick) begin
            s_nxt.ps_cnt = s_r.ps_cnt - 13'h0001;
          end
        end
      endcase
    end

    // Burst start, at most three per wake-up, pairs alternating
    s_nxt.burst = 1'b0;
    if (s_r.ps == PS_WAKE && s_nxt.ps == PS_WAKE && s_r.tick
        && s_r.burst_t == 5'h00 && s_r.bursts != 2'(`PPS_MAX_BURSTS)) begin
      s_nxt.burst  = 1'b1;
      s_nxt.bursts = s_r.bursts + 2'h1;
      s_nxt.pair_b = s_r.bursts[0];
    end
  end

  // ****************************************************
  // State register
  // ****************************************************
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_r          <= '0;
      s_r.ctrl     <= `PPS_CTRL_RST;
      s_r.tmr      <= `PPS_TMR_RST;
      s_r.wcfg     <= `PPS_WCFG_RST;
      s_r.ps       <= PS_OFF;
      s_r.det      <= DET_IDLE;
      s_r.det_stat <= `PPS_DET_SEARCHING;
      s_r.lfsr     <= 16'hACE1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  assign PRDATA  = s_r.prdata;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && s_r.pslverr;

  assign LPI_IDLE_EN = s_r.ctrl[`PPS_B_LPI_EN] && LPI_REQ && LINK_UP
                       && (SPEED == `PPS_SPD_1000
                       || (SPEED == `PPS_SPD_100
                       && !s_r.ctrl[`PPS_B_RX_FAST_DIS]));
  assign REDUCED_AMP_10 = s_r.ctrl[`PPS_B_RX_FAST_DIS];
  assign DIGITAL_PWR_DN = s_r.ctrl[`PPS_B_STD_PDN] || s_r.ps == PS_LOW;
  assign SPECIAL_FLP_EN = s_r.det == DET_SEARCH;
  assign AUTONEG_RUN    = an_en && s_r.det != DET_SEARCH && s_r.ps != PS_LOW
                          && s_r.ps != PS_WAKE;
  assign FLP_BURST      = s_r.burst;
  assign FLP_PAIR_B     = s_r.pair_b;
  assign LINK_STATUS    = s_r.link_q;
  assign PD_DETECT_STATUS = s_r.det_stat;
  assign WAKE_IRQ       = s_r.irq;
  assign WAKE_LED       = s_r.irq;

endmodule // pps_sequencer

// [inc/pps_consts.svh]
/*
  Constants of the per-port power sequencer: register offsets, field
  positions, reset values and timing figures.
  Assumes inclusion by bare name from the package, the bench and the checker.
*/
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define PPS_OFS_CTRL      12'h000
`define PPS_OFS_TIMERS    12'h004
`define PPS_OFS_STATUS    12'h008
`define PPS_OFS_IRQ_STAT  12'h00C
`define PPS_OFS_WAKE_CFG  12'h010
`define PPS_OFS_WADDR_LO  12'h014
`define PPS_OFS_WADDR_HI  12'h018

// ****************************************************
// Control bits
// ****************************************************
`define PPS_CTRL_W        7
`define PPS_B_RX_FAST_DIS 0
`define PPS_B_PS_EN       1
`define PPS_B_PD_DET_EN   2
`define PPS_B_AN_EN       3
`define PPS_B_WAKE_MASK   4
`define PPS_B_STD_PDN     5
`define PPS_B_LPI_EN      6
`define PPS_CTRL_RST      7'h08

// Timer codes: sleep [1:0], wake-up [3:2], link timeout low [4], high [5]
`define PPS_TMR_W         6
`define PPS_TMR_RST       6'h01
`define PPS_WCFG_W        2
`define PPS_B_WAKE_EN     0
`define PPS_B_PASS_EN     1
`define PPS_WCFG_RST      2'h0

// Detection status codes
`define PPS_DET_SEARCHING 2'h0
`define PPS_DET_NEEDS_PWR 2'h1
`define PPS_DET_NO_LOOP   2'h2

// Link speed codes
`define PPS_SPD_10        2'h0
`define PPS_SPD_100       2'h1
`define PPS_SPD_1000      2'h2

// ****************************************************
// Timing
// ****************************************************
`define PPS_CLK_NS        10
`define PPS_MS_NS         1000000
`define PPS_RND_SPAN      141
`define PPS_RND_NEG_MS    80
`define PPS_BURST_MS      16
`define PPS_MAX_BURSTS    3

`endif

// [inc/pps_pkg.sv]
/*
  Types of the per-port power sequencer.
  Assumes pps_consts.svh is on the include path.
*/
`include "pps_consts.svh"

package pps_pkg;

  typedef enum logic [1:0] {PS_OFF, PS_LOW, PS_WAKE, PS_NORMAL} pps_ps_t;

  typedef enum logic [1:0] {DET_IDLE, DET_SEARCH, DET_NEG} pps_det_t;

  typedef logic [1:0] pps_speed_t;

  typedef struct packed {
    logic [`PPS_CTRL_W-1:0] ctrl;
    logic [`PPS_TMR_W-1:0]  tmr;
    logic [`PPS_WCFG_W-1:0] wcfg;
    logic [47:0]            waddr;
    logic                   pend;
    logic                   irq;
    pps_ps_t                ps;
    pps_det_t               det;
    logic [1:0]             det_stat;
    logic                   link_q;
    logic [16:0]            ms_cnt;
    logic                   tick;
    logic [12:0]            ps_cnt;
    logic [15:0]            det_cnt;
    logic [4:0]             burst_t;
    logic [1:0]             bursts;
    logic                   burst;
    logic                   pair_b;
    logic [15:0]            lfsr;
    logic [31:0]            prdata;
    logic                   pslverr;
    logic [1:0]             en_sync;
    logic [1:0]             lb_sync;
  } pps_state_t;

endpackage
